// file: rtl/stamp_pkg.sv
// Package with register map, field layout and timing constants of the timestamp capture unit.
package stamp_pkg;
  localparam int NUM_PORTS = 4;
  localparam int STAMP_W = 16;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_CONFIG = 8'h25;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 8'h26;
  localparam logic [IDX_W-1:0] IDX_LINE_HI = 8'h27;
  localparam logic [IDX_W-1:0] IDX_LINE_LO = 8'h28;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h29;
  localparam logic [IDX_W-1:0] IDX_STAMP_BASE = 8'h2A;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h32;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h33;
  localparam int CFG_EDGE_BIT = 6;
  localparam int CFG_RES_LSB = 4;
  localparam int CFG_ALL_BIT = 3;
  localparam int CFG_FREE_BIT = 1;
  localparam int CFG_POINT_BIT = 0;
  localparam int CTL_FREEZE_BIT = 4;
  localparam int STS_READY_BIT = 4;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_MASK = 8'h7B;
  localparam logic [7:0] CONTROL_MASK = 8'h1F;
  localparam logic [4:0] IRQ_RESET = 5'h00;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RES0_NS = 40;
  localparam int RES1_NS = 80;
  localparam int RES2_NS = 160;
  localparam int RES3_NS = 1000;
  localparam logic [7:0] RES0_CYC = 8'(RES0_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [7:0] RES1_CYC = 8'(RES1_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [7:0] RES2_CYC = 8'(RES2_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [7:0] RES3_CYC = 8'(RES3_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage : stamp_pkg

// file: rtl/multi_port_timestamp_capture.sv
// Timestamp capture unit: AHB-Lite registers, tick counter and per-port capture.
//
// Added by the designer: the AHB-Lite slave port.
module multi_port_timestamp_capture (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic frame_sync,
  input wire logic [stamp_pkg::NUM_PORTS-1:0] line_start,
  input wire logic [stamp_pkg::NUM_PORTS-1:0] frame_start,
  output logic irq
);
  import stamp_pkg::*;

  logic [7:0] config_reg;
  logic [7:0] control_reg;
  logic [15:0] capture_line_number;
  logic [7:0] addr_reg;
  logic wr_pend_reg;
  logic rd_wait_reg;
  logic [31:0] hrdata_reg;
  logic fs_prev_reg;
  logic [7:0] div_reg;
  logic [STAMP_W-1:0] stamp_reg;
  logic [NUM_PORTS-1:0] valid_reg;
  logic captures_ready_flag;
  logic [4:0] irq_status_reg;
  logic [4:0] irq_mask_reg;
  logic [STAMP_W-1:0] stamp_val_reg [NUM_PORTS];
  logic [15:0] line_cnt_reg [NUM_PORTS];

  // Bus decode. Writes are stored at the end of their data phase, when hwdata stands,
  // so the index of a write is held in addr_reg for one cycle.
  wire accept = hsel && htrans == HTRANS_NONSEQ && hready;
  wire [IDX_W-1:0] acc_idx = haddr[IDX_W+1:2];
  wire wr_config = wr_pend_reg && addr_reg == IDX_CONFIG;
  wire wr_control = wr_pend_reg && addr_reg == IDX_CONTROL;
  wire wr_line_hi = wr_pend_reg && addr_reg == IDX_LINE_HI;
  wire wr_line_lo = wr_pend_reg && addr_reg == IDX_LINE_LO;
  wire wr_irq_sts = wr_pend_reg && addr_reg == IDX_IRQ_STATUS;
  wire wr_irq_mask = wr_pend_reg && addr_reg == IDX_IRQ_MASK;
  wire [IDX_W-1:0] stamp_off = addr_reg - IDX_STAMP_BASE;
  wire in_stamps = addr_reg >= IDX_STAMP_BASE && stamp_off < IDX_W'(2 * NUM_PORTS);
  wire [STAMP_W-1:0] sel_stamp = stamp_val_reg[stamp_off[2:1]];
  wire [7:0] sel_byte = stamp_off[0] ? sel_stamp[7:0] : sel_stamp[15:8];

  // Configuration fields.
  wire sync_edge_select = config_reg[CFG_EDGE_BIT];
  wire [1:0] tick_resolution_sel = config_reg[CFG_RES_LSB +: 2];
  wire ready_when_all_present = config_reg[CFG_ALL_BIT];
  wire free_running_select = config_reg[CFG_FREE_BIT];
  wire capture_point_select = config_reg[CFG_POINT_BIT];
  wire hold_captured_values = control_reg[CTL_FREEZE_BIT];
  wire [NUM_PORTS-1:0] port_capture_enable = control_reg[NUM_PORTS-1:0];
  wire freeze_set = wr_control && hwdata[CTL_FREEZE_BIT];
  wire freeze_release = wr_control && !hwdata[CTL_FREEZE_BIT] && hold_captured_values;

  // Tick generation and counter.
  // The divider compares with >= so that a switch to a finer resolution ends the
  // current tick at once instead of letting the divider run through its whole range.
  wire fs_rise = frame_sync && !fs_prev_reg;
  wire fs_fall = !frame_sync && fs_prev_reg;
  wire fs_active = sync_edge_select ? fs_fall : fs_rise;
  wire stamp_restart = fs_active && !free_running_select;
  wire [7:0] tick_len = tick_resolution_sel == 2'b00 ? RES0_CYC :
                        tick_resolution_sel == 2'b01 ? RES1_CYC :
                        tick_resolution_sel == 2'b10 ? RES2_CYC : RES3_CYC;
  wire tick = div_reg >= tick_len - 8'h01;

  // Capture events per port.
  // Each port keeps its own line counter, cleared at its frame start and saturating at
  // the top, so a long frame cannot wrap round and capture a second time.
  logic [NUM_PORTS-1:0] cap;
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      wire at_line = line_start[p] && (line_cnt_reg[p] + 16'h0001) == capture_line_number;
      wire armed = !free_running_select || line_cnt_reg[p] >= capture_line_number;
      wire event_hit = capture_point_select ? (frame_start[p] && armed) : at_line;
      assign cap[p] = event_hit && port_capture_enable[p] && !hold_captured_values;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          line_cnt_reg[p] <= 16'h0000;
          stamp_val_reg[p] <= 16'h0000;
        end else begin
          if (frame_start[p]) begin
            line_cnt_reg[p] <= 16'h0000;
          end else if (line_start[p] && line_cnt_reg[p] != 16'hFFFF) begin
            line_cnt_reg[p] <= line_cnt_reg[p] + 16'h0001;
          end
          if (cap[p]) begin
            stamp_val_reg[p] <= stamp_reg;
          end
        end
      end
    end
  endgenerate

  // Readiness.
  // A freeze write wins over a capture that would make the stamps ready in the same
  // cycle, so software never sees ready while the values are held.
  wire all_in = port_capture_enable != '0 &&
                (valid_reg & port_capture_enable) == port_capture_enable;
  wire ready_cond = ready_when_all_present ? all_in : (all_in && fs_active);
  wire ready_set = ready_cond && !hold_captured_values && !freeze_set;
  wire ready_next = freeze_set ? 1'b0 : (ready_set ? 1'b1 : captures_ready_flag);

  // Interrupt status: bit 0 readiness, bits 4:1 port captures.
  wire [4:0] irq_events = {cap, ready_set && !captures_ready_flag};
  wire [4:0] irq_clear = wr_irq_sts ? hwdata[4:0] : 5'h00;
  wire [4:0] irq_status_next = irq_events | (irq_status_reg & ~irq_clear);

  // Read mux.
  // Read data are latched one cycle after the address phase, so a read that follows a
  // write to the same register returns the new value.
  wire [7:0] status_byte = {3'b000, captures_ready_flag, valid_reg};
  wire [7:0] rd_byte = addr_reg == IDX_CONFIG ? config_reg :
                       addr_reg == IDX_CONTROL ? control_reg :
                       addr_reg == IDX_LINE_HI ? capture_line_number[15:8] :
                       addr_reg == IDX_LINE_LO ? capture_line_number[7:0] :
                       addr_reg == IDX_STATUS ? status_byte :
                       addr_reg == IDX_IRQ_STATUS ? {3'b000, irq_status_reg} :
                       addr_reg == IDX_IRQ_MASK ? {3'b000, irq_mask_reg} :
                       in_stamps ? sel_byte : 8'h00;

  assign hrdata = hrdata_reg;
  assign hreadyout = !rd_wait_reg;
  assign hresp = HRESP_OKAY;
  assign irq = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= accept && hwrite;
      rd_wait_reg <= accept && !hwrite;
      if (accept) begin
        addr_reg <= acc_idx;
      end
      if (rd_wait_reg) begin
        hrdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_reg <= CONFIG_RESET;
      control_reg <= CONTROL_RESET;
      capture_line_number <= 16'h0000;
      irq_mask_reg <= IRQ_RESET;
    end else begin
      if (wr_config) config_reg <= hwdata[7:0] & CONFIG_MASK;
      if (wr_control) control_reg <= hwdata[7:0] & CONTROL_MASK;
      if (wr_line_hi) capture_line_number[15:8] <= hwdata[7:0];
      if (wr_line_lo) capture_line_number[7:0] <= hwdata[7:0];
      if (wr_irq_mask) irq_mask_reg <= hwdata[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_prev_reg <= 1'b0;
      div_reg <= 8'h00;
      stamp_reg <= 16'h0000;
    end else begin
      fs_prev_reg <= frame_sync;
      // The active edge restarts divider and count together, so the first tick comes
      // one full resolution period after the edge.
      if (stamp_restart) begin
        div_reg <= 8'h00;
        stamp_reg <= 16'h0000;
      end else if (tick) begin
        div_reg <= 8'h00;
        stamp_reg <= stamp_reg + 16'h0001;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_reg <= '0;
      captures_ready_flag <= 1'b0;
      irq_status_reg <= IRQ_RESET;
    end else begin
      captures_ready_flag <= ready_next;
      irq_status_reg <= irq_status_next;
      // A new round starts when software lifts the freeze.
      valid_reg <= freeze_release ? cap : (valid_reg | cap);
    end
  end

  // Assertions run on the core clock and stay quiet while reset is asserted.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_status;
    accept && !hwrite && acc_idx == IDX_STATUS;
  endsequence
  sequence s_rd_stamp_hi;
    accept && !hwrite && acc_idx == IDX_STAMP_BASE;
  endsequence
  sequence s_rd_stamp_lo;
    accept && !hwrite && acc_idx == IDX_STAMP_BASE + 8'h01;
  endsequence

  a_edge_restart: assert property (
    (!free_running_select && !config_reg[CFG_EDGE_BIT] && frame_sync && !$past(frame_sync)
     && !wr_config) |=> stamp_reg == 16'h0000)
    else $error("Rising frame-sync edge did not restart the counter.");
  a_tick_step: assert property (
    (!stamp_restart && div_reg == tick_len - 8'h01) |=> stamp_reg == $past(stamp_reg) + 16'h0001)
    else $error("Counter did not advance at the end of the tick period.");
  a_all_ready: assert property (
    (ready_when_all_present && all_in && !hold_captured_values && !freeze_set)
    |=> captures_ready_flag)
    else $error("Ready did not rise with all enabled ports captured.");
  a_freerun_hold: assert property (
    (free_running_select && !tick) |=> stamp_reg == $past(stamp_reg))
    else $error("Counter moved without a tick in free-running mode.");
  a_capture_gate: assert property (
    (!port_capture_enable[0] || hold_captured_values)
    |=> stamp_val_reg[0] == $past(stamp_val_reg[0]))
    else $error("Port 0 captured while disabled or frozen.");
  a_port3_gate: assert property (
    !port_capture_enable[3] |=> stamp_val_reg[3] == $past(stamp_val_reg[3]))
    else $error("Port 3 captured while disabled.");
  a_fall_restart: assert property (
    (!free_running_select && sync_edge_select && !frame_sync && $past(frame_sync)
     && !wr_config) |=> stamp_reg == 16'h0000)
    else $error("Falling frame-sync edge did not restart the counter.");
  a_frame_capture: assert property (
    (capture_point_select && !free_running_select && frame_start[0] && port_capture_enable[0]
     && !hold_captured_values) |=> stamp_val_reg[0] == $past(stamp_reg) && valid_reg[0])
    else $error("Frame-start capture missed on port 0.");
  a_armed_frame: assert property (
    (capture_point_select && free_running_select && frame_start[0]
     && line_cnt_reg[0] < capture_line_number) |=> stamp_val_reg[0] == $past(stamp_val_reg[0]))
    else $error("Free-run frame start captured before the programmed line.");
  a_frozen_ready: assert property (
    (hold_captured_values && !captures_ready_flag) |=> !captures_ready_flag)
    else $error("Ready rose while frozen.");
  a_ready_normal: assert property (
    (!ready_when_all_present && !fs_active && !captures_ready_flag) |=> !captures_ready_flag)
    else $error("Ready rose without an active frame-sync edge.");
  a_status_readonly: assert property (
    (wr_pend_reg && addr_reg == IDX_STATUS && !cap[0] && !freeze_release)
    |=> valid_reg[0] == $past(valid_reg[0]))
    else $error("Status write changed a valid bit.");
  a_release_clears: assert property (
    (freeze_release && !cap[0]) |=> !valid_reg[0])
    else $error("Lifting the freeze did not clear the valid bit.");
  a_w1c_set_wins: assert property (
    (wr_irq_sts && hwdata[1] && cap[0]) |=> irq_status_reg[1])
    else $error("Clear beat a same-cycle capture event.");
  a_freeze_clear: assert property (
    freeze_set |=> !captures_ready_flag && hold_captured_values ##1 !captures_ready_flag)
    else $error("Freeze write did not clear ready.");
  a_frozen_stable: assert property (
    hold_captured_values |=> stamp_val_reg[1] == $past(stamp_val_reg[1]))
    else $error("Captured value changed while frozen.");
  a_line_capture: assert property (
    (!capture_point_select && port_capture_enable[0] && !hold_captured_values
     && line_start[0] && line_cnt_reg[0] + 16'h0001 == capture_line_number)
    |=> stamp_val_reg[0] == $past(stamp_reg) && valid_reg[0])
    else $error("Line-start capture missed the programmed line.");
  a_status_read: assert property (
    s_rd_status |=> !hreadyout ##1 hreadyout && hrdata[STS_READY_BIT] == $past(captures_ready_flag))
    else $error("Status read did not return the ready flag.");
  a_stamp_read: assert property (
    s_rd_stamp_hi |=> ##1 hrdata[7:0] == $past(stamp_val_reg[0][15:8]))
    else $error("Port 0 upper byte read mismatch.");
  a_stamp_lo_read: assert property (
    s_rd_stamp_lo |=> ##1 hrdata[7:0] == $past(stamp_val_reg[0][7:0]))
    else $error("Port 0 lower byte read mismatch.");
  a_stamp_p3_read: assert property (
    (accept && !hwrite && acc_idx == IDX_STAMP_BASE + 8'h06)
    |=> ##1 hrdata[7:0] == $past(stamp_val_reg[3][15:8]))
    else $error("Port 3 upper byte read mismatch.");
endmodule : multi_port_timestamp_capture

// file: bench/video_stream_model.sv
// Behavioural source of frame sync and per-port line and frame start pulses.
module video_stream_model (
  input wire logic hclk,
  output logic frame_sync,
  output logic [3:0] line_start,
  output logic [3:0] frame_start
);
  initial begin
    frame_sync = 1'b0;
    line_start = 4'h0;
    frame_start = 4'h0;
  end
  // The inactive edge comes gap cycles early, so a wrong edge choice shifts the stamp.
  task automatic sync_edge(input logic pol, input int gap);
    frame_sync <= pol;
    repeat (gap) @(posedge hclk);
    frame_sync <= ~pol;
    @(posedge hclk);
  endtask : sync_edge
  task automatic pulse(input logic is_line, input logic [3:0] ports);
    if (is_line) begin
      line_start <= ports;
    end else begin
      frame_start <= ports;
    end
    @(posedge hclk);
    line_start <= 4'h0;
    frame_start <= 4'h0;
    @(posedge hclk);
  endtask : pulse
endmodule : video_stream_model

// file: bench/tb_top.sv
// Self-checking bench of the timestamp capture unit.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stamp_pkg::*;
  typedef struct {logic [1:0] code; int k;} row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, irq, frame_sync;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [3:0] line_start, frame_start;
  logic [7:0] rd, hi;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int p;
  int per [4];
  row_t rows [4];
  multi_port_timestamp_capture DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_sync(frame_sync), .line_start(line_start), .frame_start(frame_start), .irq(irq));
  video_stream_model src (.hclk(hclk), .frame_sync(frame_sync), .line_start(line_start),
    .frame_start(frame_start));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_reg
  // Sampled at the falling edge so that the last write has landed.
  task automatic chk_irq(input logic exp);
    @(negedge hclk);
    cmp_count++;
    if (irq !== exp) begin
      n_mismatch++;
      $display("mismatch irq expected %b seen %b", exp, irq);
    end
    @(posedge hclk);
  endtask : chk_irq
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask : wr
  task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    chk_reg(name, {8'h00, exp}, {8'h00, rd});
  endtask : rdc
  initial begin
    per = '{int'(RES0_CYC), int'(RES1_CYC), int'(RES2_CYC), int'(RES3_CYC)};
    rows = '{'{2'h0, 300}, '{2'h1, 7}, '{2'h2, 5}, '{2'h3, 3}};
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    chk_irq(1'b0);
    for (int i = 8'h24; i <= 8'h34; i++) rdc("reset value", 8'(i), 8'h00);
    chk_reg("hresp", 16'(HRESP_OKAY), {14'h0000, hresp});
    wr(IDX_CONFIG, 8'hFF);
    rdc("config", IDX_CONFIG, 8'h7B);
    wr(IDX_CONTROL, 8'hFF);
    rdc("control", IDX_CONTROL, 8'h1F);
    wr(IDX_LINE_HI, 8'hAB);
    rdc("line hi", IDX_LINE_HI, 8'hAB);
    wr(IDX_STATUS, 8'hFF);
    rdc("status", IDX_STATUS, 8'h00);
    wr(IDX_STAMP_BASE, 8'hFF);
    rdc("stamp", IDX_STAMP_BASE, 8'h00);
    wr(8'h40, 8'hFF);
    rdc("unmapped", 8'h40, 8'h00);
    wr(IDX_LINE_HI, 8'h00);
    wr(IDX_LINE_LO, 8'h02);
    foreach (rows[r]) begin
      p = per[rows[r].code];
      wr(IDX_CONFIG, {1'b0, rows[r].code[0], rows[r].code, 4'h0});
      wr(IDX_CONTROL, 8'h11);
      wr(IDX_CONTROL, 8'h01);
      src.pulse(1'b0, 4'h1);
      src.pulse(1'b1, 4'h1);
      src.sync_edge(rows[r].code[0], 4 * p);
      repeat (rows[r].k * p + p / 2) @(posedge hclk);
      src.pulse(1'b1, 4'h1);
      bus(1'b0, IDX_STAMP_BASE, 8'h00, hi);
      bus(1'b0, 8'(IDX_STAMP_BASE + 1), 8'h00, rd);
      chk_reg("stamp", 16'(rows[r].k), {hi, rd});
      rdc("status", IDX_STATUS, 8'h01);
      src.sync_edge(rows[r].code[0], 2);
      rdc("status", IDX_STATUS, 8'h11);
    end
    chk_irq(1'b0);
    rdc("irq status", IDX_IRQ_STATUS, 8'h03);
    wr(IDX_IRQ_MASK, 8'h02);
    chk_irq(1'b1);
    wr(IDX_IRQ_STATUS, 8'h02);
    chk_irq(1'b0);
    rdc("irq status", IDX_IRQ_STATUS, 8'h01);
    wr(IDX_CONFIG, 8'h09);
    wr(IDX_CONTROL, 8'h11);
    wr(IDX_CONTROL, 8'h01);
    src.sync_edge(1'b0, 2);
    repeat (5 * per[0] + per[0] / 2) @(posedge hclk);
    src.pulse(1'b0, 4'h3);
    rdc("status", IDX_STATUS, 8'h11);
    wr(IDX_CONTROL, 8'h11);
    rdc("status", IDX_STATUS, 8'h01);
    src.pulse(1'b0, 4'h1);
    rdc("stamp lo", 8'(IDX_STAMP_BASE + 1), 8'h05);
    wr(IDX_CONTROL, 8'h01);
    rdc("status", IDX_STATUS, 8'h00);
    wr(IDX_CONFIG, 8'h0B);
    src.pulse(1'b0, 4'h1);
    rdc("status", IDX_STATUS, 8'h00);
    src.pulse(1'b1, 4'h1);
    src.pulse(1'b1, 4'h1);
    src.pulse(1'b0, 4'h1);
    rdc("status", IDX_STATUS, 8'h11);
    final_report();
  end
endmodule : tb_top
